//--- ssviu_pkg.sv
// constants, register map and priority tables of the six-source vectored interrupt unit
package ssviu_pkg;

    localparam int SSVIU_NUM_SRC = 6;
    localparam int SSVIU_NUM_CH = 7;
    localparam int SSVIU_ADDR_W = 12;

    // register indexes; byte address is four times the index
    localparam logic [7:0] SSVIU_IDX_RANK = 8'hF9;
    localparam logic [7:0] SSVIU_IDX_STATUS = 8'hFA;
    localparam logic [7:0] SSVIU_IDX_MASK = 8'hFB;
    localparam logic [7:0] SSVIU_IDX_CTRL = 8'hFC;
    localparam logic [11:0] SSVIU_ADDR_RANK = {2'h0, SSVIU_IDX_RANK, 2'h0};
    localparam logic [11:0] SSVIU_ADDR_STATUS = {2'h0, SSVIU_IDX_STATUS, 2'h0};
    localparam logic [11:0] SSVIU_ADDR_MASK = {2'h0, SSVIU_IDX_MASK, 2'h0};
    localparam logic [11:0] SSVIU_ADDR_CTRL = {2'h0, SSVIU_IDX_CTRL, 2'h0};

    // field positions
    localparam int SSVIU_RANK_GRP_LSB = 0;
    localparam int SSVIU_RANK_C_BIT = 3;
    localparam int SSVIU_RANK_B_BIT = 4;
    localparam int SSVIU_RANK_A_BIT = 5;
    localparam int SSVIU_MASK_GLOBAL_BIT = 7;
    localparam int SSVIU_CTRL_A_DV_BIT = 0;
    localparam int SSVIU_CTRL_C_SEL_LSB = 1;
    localparam int SSVIU_CTRL_HALT_BIT = 4;

    // reset values
    localparam logic [7:0] SSVIU_RANK_RST = 8'h00;
    localparam logic [7:0] SSVIU_MASK_RST = 8'h00;
    localparam logic [2:0] SSVIU_CTRL_RST = 3'h0;
    localparam logic [5:0] SSVIU_PEND_RST = 6'h00;
    localparam logic [31:0] SSVIU_RDATA_ZERO = 32'h00000000;

    // request identities; vector pair starts at twice the identity
    localparam logic [2:0] SSVIU_ID_A = 3'h0;
    localparam logic [2:0] SSVIU_ID_B = 3'h1;
    localparam logic [2:0] SSVIU_ID_C = 3'h2;
    localparam logic [2:0] SSVIU_ID_D = 3'h3;
    localparam logic [2:0] SSVIU_ID_T0 = 3'h4;
    localparam logic [2:0] SSVIU_ID_T1 = 3'h5;

    // edge detector modes
    localparam logic [1:0] SSVIU_EDGE_RISE = 2'h1;
    localparam logic [1:0] SSVIU_EDGE_FALL = 2'h2;
    localparam logic [1:0] SSVIU_EDGE_BOTH = 2'h3;

    // source selections for ext_req_c
    localparam logic [1:0] SSVIU_C_SRC_PIN = 2'h0;
    localparam logic [1:0] SSVIU_C_SRC_DV = 2'h1;

    // groups: 0 = A, 1 = B, 2 = C
    localparam logic [1:0] SSVIU_GRP_A = 2'h0;
    localparam logic [1:0] SSVIU_GRP_B = 2'h1;
    localparam logic [1:0] SSVIU_GRP_C = 2'h2;

    // order of the three groups, highest first, per group-order code
    function automatic logic [5:0] ssviu_group_order(input logic [2:0] code);
        case (code)
            3'h1: ssviu_group_order = {SSVIU_GRP_C, SSVIU_GRP_A, SSVIU_GRP_B};
            3'h2: ssviu_group_order = {SSVIU_GRP_A, SSVIU_GRP_B, SSVIU_GRP_C};
            3'h3: ssviu_group_order = {SSVIU_GRP_A, SSVIU_GRP_C, SSVIU_GRP_B};
            3'h4: ssviu_group_order = {SSVIU_GRP_B, SSVIU_GRP_C, SSVIU_GRP_A};
            3'h5: ssviu_group_order = {SSVIU_GRP_C, SSVIU_GRP_B, SSVIU_GRP_A};
            3'h6: ssviu_group_order = {SSVIU_GRP_B, SSVIU_GRP_A, SSVIU_GRP_C};
            default: ssviu_group_order = {SSVIU_GRP_A, SSVIU_GRP_B, SSVIU_GRP_C};
        endcase
    endfunction

endpackage

//--- ssviu_edge_if.sv
// level in, edge pulse out, between the unit and its edge detectors
interface ssviu_edge_if;
    logic level;
    logic enable;
    logic pulse;
    modport det (input level, input enable, output pulse);
    modport user (output level, output enable, input pulse);
endinterface

//--- ssviu_edge_det.sv
// edge detector for one request input
module ssviu_edge_det
    import ssviu_pkg::*;
#(
    parameter logic [1:0] MODE = SSVIU_EDGE_BOTH
)
(
    input wire logic pclk,
    input wire logic presetn,
    ssviu_edge_if.det e
);

    logic prev;
    logic armed;
    wire rose = e.level & ~prev;
    wire fell = ~e.level & prev;

    // no edge is reported before a first sample has been taken
    assign e.pulse = armed & e.enable & ((rose & MODE[0]) | (fell & MODE[1]));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev <= 1'b0;
            armed <= 1'b0;
        end
        else
        begin
            prev <= e.level;
            armed <= 1'b1;
        end
    end

endmodule

//--- ssviu_unit.sv
// six-source vectored interrupt unit with apb registers and halt wake-up
//
// Chosen here: the APB register port.
module ssviu_unit
    import ssviu_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] port3_pin,
    input wire logic port_a_data_valid_n,
    input wire logic port_c_data_valid_n,
    input wire logic timer_in_pin,
    input wire logic counter_zero,
    input wire logic counter_one,
    input wire logic halt_cmd,
    input wire logic service_ack,
    output logic irq,
    output logic [3:0] vector_loc,
    output logic cpu_clk_run
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [7:0] rank;
    logic [7:0] mask;
    logic [2:0] ctrl;
    logic [5:0] pending;
    logic [2:0] vec_id;
    logic halted;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    wire access = psel & penable & ~pready;
    wire done = psel & penable & pready;
    wire wr_done = done & pwrite;
    wire rd_access = access & ~pwrite;
    wire sel_rank = paddr == SSVIU_ADDR_RANK;
    wire sel_status = paddr == SSVIU_ADDR_STATUS;
    wire sel_mask = paddr == SSVIU_ADDR_MASK;
    wire sel_ctrl = paddr == SSVIU_ADDR_CTRL;
    wire mapped = sel_rank | sel_status | sel_mask | sel_ctrl;

    // rank register is write-only and reads as zero
    wire [31:0] rd_mux = sel_status ? {26'h0, pending} :
                         sel_mask ? {24'h0, mask} :
                         sel_ctrl ? {27'h0, halted, 1'b0, ctrl} : SSVIU_RDATA_ZERO;

    // status clears when it is sampled, so a set in the same edge survives
    wire [5:0] rd_clear = (rd_access & sel_status) ? pending : 6'h00;

    ////////////////////////////////////////////////////////////////////////////
    // edge detection

    ssviu_edge_if ch [SSVIU_NUM_CH] ();

    localparam logic [1:0] CH_MODE [SSVIU_NUM_CH] = '{SSVIU_EDGE_BOTH, SSVIU_EDGE_FALL, SSVIU_EDGE_BOTH,
        SSVIU_EDGE_FALL, SSVIU_EDGE_FALL, SSVIU_EDGE_FALL, SSVIU_EDGE_FALL};

    wire [SSVIU_NUM_CH-1:0] ch_level = {timer_in_pin, port_c_data_valid_n, port_a_data_valid_n,
                                        port3_pin[0], port3_pin[1], port3_pin[3], port3_pin[2]};
    // ext_req_d is not watched while halted; a, b and c stay live
    wire [SSVIU_NUM_CH-1:0] ch_enable = {{3{1'b1}}, ~halted, {3{1'b1}}};
    wire [SSVIU_NUM_CH-1:0] ch_pulse;

    genvar gi;
    generate
        for (gi = 0; gi < SSVIU_NUM_CH; gi++)
        begin : g_ch
            assign ch[gi].level = ch_level[gi];
            assign ch[gi].enable = ch_enable[gi];
            assign ch_pulse[gi] = ch[gi].pulse;
            ssviu_edge_det #(.MODE(CH_MODE[gi])) u_det (
                .pclk(pclk),
                .presetn(presetn),
                .e(ch[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // request events

    wire [1:0] c_sel = ctrl[SSVIU_CTRL_C_SEL_LSB +: 2];
    wire ev_a = ctrl[SSVIU_CTRL_A_DV_BIT] ? ch_pulse[4] : ch_pulse[0];
    wire ev_b = ch_pulse[1];
    wire ev_c = (c_sel == SSVIU_C_SRC_PIN) ? ch_pulse[2] :
                (c_sel == SSVIU_C_SRC_DV) ? ch_pulse[5] : ch_pulse[6];
    wire ev_d = ch_pulse[3];
    // timers are outside this block and keep counting through halt
    wire [5:0] events = {counter_one, counter_zero, ev_d, ev_c, ev_b, ev_a};

    wire [5:0] ack_clear = (service_ack && irq) ? (6'h01 << vec_id) : 6'h00;
    // a new event wins over any clear in the same edge
    wire [5:0] next_pending = (pending & ~(ack_clear | rd_clear)) | events;

    ////////////////////////////////////////////////////////////////////////////
    // prioritisation

    wire [5:0] eligible = next_pending & mask[5:0] & {6{mask[SSVIU_MASK_GLOBAL_BIT]}};
    wire [5:0] live = pending & mask[5:0] & {6{mask[SSVIU_MASK_GLOBAL_BIT]}};

    localparam logic [2:0] GRP_HI [3] = '{SSVIU_ID_T1, SSVIU_ID_C, SSVIU_ID_B};
    localparam logic [2:0] GRP_LO [3] = '{SSVIU_ID_D, SSVIU_ID_A, SSVIU_ID_T0};
    localparam int GRP_SWAP [3] = '{SSVIU_RANK_A_BIT, SSVIU_RANK_B_BIT, SSVIU_RANK_C_BIT};

    logic [2:0] grp_id [3];
    logic [2:0] grp_valid;

    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_grp
            wire [2:0] first = rank[GRP_SWAP[gi]] ? GRP_LO[gi] : GRP_HI[gi];
            wire [2:0] second = rank[GRP_SWAP[gi]] ? GRP_HI[gi] : GRP_LO[gi];
            assign grp_valid[gi] = eligible[GRP_HI[gi]] | eligible[GRP_LO[gi]];
            assign grp_id[gi] = eligible[first] ? first : second;
        end
    endgenerate

    wire [5:0] order = ssviu_group_order(rank[SSVIU_RANK_GRP_LSB +: 3]);
    wire [1:0] ord1 = order[5:4];
    wire [1:0] ord2 = order[3:2];
    wire [1:0] ord3 = order[1:0];
    wire [1:0] win_grp = grp_valid[ord1] ? ord1 : grp_valid[ord2] ? ord2 : ord3;
    wire [2:0] win_id = grp_id[win_grp];
    wire any_eligible = |eligible;

    ////////////////////////////////////////////////////////////////////////////
    // halt control

    // halt_cmd is trusted to come after the core has drained its pipeline
    wire next_halted = halted ? ~(|live) : halt_cmd;

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= SSVIU_RDATA_ZERO;
        end
        else
        begin
            pready <= access;
            pslverr <= access & ~mapped;
            prdata <= rd_access ? rd_mux : SSVIU_RDATA_ZERO;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rank <= SSVIU_RANK_RST;
            mask <= SSVIU_MASK_RST;
            ctrl <= SSVIU_CTRL_RST;
        end
        else if (wr_done)
        begin
            if (sel_rank)
                rank <= pwdata[7:0];
            if (sel_mask)
                mask <= pwdata[7:0];
            if (sel_ctrl)
                ctrl <= pwdata[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pending <= SSVIU_PEND_RST;
            vec_id <= SSVIU_ID_A;
            irq <= 1'b0;
            vector_loc <= 4'h0;
        end
        else
        begin
            pending <= next_pending;
            vec_id <= win_id;
            irq <= any_eligible;
            vector_loc <= {win_id, 1'b0};
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            halted <= 1'b0;
            cpu_clk_run <= 1'b1;
        end
        else
        begin
            halted <= next_halted;
            cpu_clk_run <= ~next_halted;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_b_fall;
        $past(presetn) && $fell(port3_pin[3]) |=> pending[1];
    endproperty
    a_b_fall: assert property (p_b_fall) else $error("falling pin 3 did not post ext_req_b");

    property p_b_no_rise;
        $rose(port3_pin[3]) |-> !ev_b;
    endproperty
    a_b_no_rise: assert property (p_b_no_rise) else $error("rising pin 3 posted ext_req_b");

    property p_d_quiet_halt;
        halted |-> !ev_d;
    endproperty
    a_d_quiet_halt: assert property (p_d_quiet_halt) else $error("ext_req_d edge seen in halt");

    property p_global_off;
        !mask[SSVIU_MASK_GLOBAL_BIT] ##1 !mask[SSVIU_MASK_GLOBAL_BIT] |-> !irq;
    endproperty
    a_global_off: assert property (p_global_off) else $error("irq raised with global enable off");

    property p_vec_range;
        irq |-> !vector_loc[0] && vector_loc <= 4'hA && live[vector_loc[3:1]];
    endproperty
    a_vec_range: assert property (p_vec_range) else $error("vector does not match a live request");

    property p_group_c;
        eligible == 6'h12 && rank[SSVIU_RANK_C_BIT] |=> vector_loc == 4'h8;
    endproperty
    a_group_c: assert property (p_group_c) else $error("group C ranking wrong");

    property p_group_order;
        eligible == 6'h03 && rank[2:0] == 3'h1 |=> vector_loc == 4'h2;
    endproperty
    a_group_order: assert property (p_group_order) else $error("group order C first not kept");

    property p_halt_exit;
        halted && |live |=> !halted && cpu_clk_run && irq;
    endproperty
    a_halt_exit: assert property (p_halt_exit) else $error("halt not left on enabled request");

    property p_halt_gate;
        halted |-> !cpu_clk_run;
    endproperty
    a_halt_gate: assert property (p_halt_gate) else $error("cpu clock runs in halt");

    property p_ack_keeps_others;
        service_ack && irq && events == 6'h00 && !rd_access |=> pending == ($past(pending) & ~(6'h01 << $past(vec_id)));
    endproperty
    a_ack_keeps_others: assert property (p_ack_keeps_others) else $error("service clear wrong");

    property p_apb_wait;
        psel && penable && !pready |=> pready ##1 !pready;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("apb answer timing wrong");

    property p_a_pin;
        !ctrl[SSVIU_CTRL_A_DV_BIT] && $changed(port3_pin[2]) && $past(presetn) |=> pending[0];
    endproperty
    a_a_pin: assert property (p_a_pin) else $error("pin 2 edge did not post ext_req_a");

    property p_a_dv;
        ctrl[SSVIU_CTRL_A_DV_BIT] && $fell(port_a_data_valid_n) && $past(presetn) |=> pending[0];
    endproperty
    a_a_dv: assert property (p_a_dv) else $error("port a handshake did not post ext_req_a");

    property p_c_pin;
        c_sel == SSVIU_C_SRC_PIN && $changed(port3_pin[1]) && $past(presetn) |=> pending[2];
    endproperty
    a_c_pin: assert property (p_c_pin) else $error("pin 1 edge did not post ext_req_c");

    property p_c_timer;
        c_sel[1] && $fell(timer_in_pin) && $past(presetn) |=> pending[2];
    endproperty
    a_c_timer: assert property (p_c_timer) else $error("timer input did not post ext_req_c");

    property p_d_fall;
        !halted && $fell(port3_pin[0]) && $past(presetn) |=> pending[3];
    endproperty
    a_d_fall: assert property (p_d_fall) else $error("falling pin 0 did not post ext_req_d");

    // checks the whole path, not only the detector enable
    property p_d_lost_halt;
        halted && $fell(port3_pin[0]) && !pending[3] |=> !pending[3];
    endproperty
    a_d_lost_halt: assert property (p_d_lost_halt) else $error("ext_req_d latched in halt");

    property p_t0_post;
        counter_zero |=> pending[4];
    endproperty
    a_t0_post: assert property (p_t0_post) else $error("counter_zero did not post timer0_req");

    property p_t1_post;
        counter_one |=> pending[5];
    endproperty
    a_t1_post: assert property (p_t1_post) else $error("counter_one did not post timer1_req");

    // irq lags the mask by one edge, so only judge it while the mask is steady
    property p_mask_each;
        $stable(mask) && irq |-> mask[SSVIU_MASK_GLOBAL_BIT] && mask[vector_loc[3:1]];
    endproperty
    a_mask_each: assert property (p_mask_each) else $error("irq for a disabled request");

    property p_halt_enter;
        !halted && halt_cmd |=> halted && !cpu_clk_run;
    endproperty
    a_halt_enter: assert property (p_halt_enter) else $error("halt not entered");

    property p_halt_hold;
        halted && !(|live) |=> halted;
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("halt left with no enabled request");

    c_halt_exit: cover property (halted ##1 !halted);
    c_ack: cover property (service_ack && irq ##1 irq);
    c_read_clear: cover property (rd_access && sel_status && |pending);
    c_swap_a: cover property (eligible == 6'h28 && rank[SSVIU_RANK_A_BIT]);

endmodule

//--- ssviu_src_model.sv
// far-side model: request pins, handshake and timer lines, counter pulses
module ssviu_src_model (
    input wire logic pclk,
    output logic [3:0] port3_pin,
    output logic port_a_data_valid_n,
    output logic port_c_data_valid_n,
    output logic timer_in_pin,
    output logic counter_zero,
    output logic counter_one
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        port3_pin = 4'hF;
        port_a_data_valid_n = 1'b1;
        port_c_data_valid_n = 1'b1;
        timer_in_pin = 1'b1;
        counter_zero = 1'b0;
        counter_one = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one edge per selected source; falling-only pins go back high next cycle,
    // so their rising edge must post nothing
    task automatic fire(input logic [5:0] w);
        @(posedge pclk);
        port3_pin[2] <= port3_pin[2] ^ w[0];
        port3_pin[3] <= ~w[1];
        port3_pin[1] <= port3_pin[1] ^ w[2];
        port3_pin[0] <= ~w[3];
        counter_zero <= w[4];
        counter_one <= w[5];
        @(posedge pclk);
        port3_pin[3] <= 1'b1;
        port3_pin[0] <= 1'b1;
        counter_zero <= 1'b0;
        counter_one <= 1'b0;
    endtask

    // one falling edge: 0 port a handshake, 1 port c handshake, 2 timer input
    task automatic strobe(input int s);
        @(posedge pclk);
        port_a_data_valid_n <= (s != 0);
        port_c_data_valid_n <= (s != 1);
        timer_in_pin <= (s != 2);
        @(posedge pclk);
        port_a_data_valid_n <= 1'b1;
        port_c_data_valid_n <= 1'b1;
        timer_in_pin <= 1'b1;
    endtask
endmodule

//--- six_source_vectored_interrupt_unit_tb_top.sv
// self-checking testbench of the six-source vectored interrupt unit
module six_source_vectored_interrupt_unit_tb_top
    import ssviu_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic halt_cmd = 1'b0;
    logic service_ack = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, port_a_data_valid_n, port_c_data_valid_n, timer_in_pin;
    logic counter_zero, counter_one, irq, cpu_clk_run;
    logic [3:0] port3_pin, vector_loc;
    logic [5:0] pend = 6'h00;
    logic [7:0] r, m;
    int errors = 0;
    int compares = 0;
    int seed = 32'hA5371651;

    always #2 pclk = ~pclk;

    ssviu_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port3_pin(port3_pin), .port_a_data_valid_n(port_a_data_valid_n),
        .port_c_data_valid_n(port_c_data_valid_n), .timer_in_pin(timer_in_pin),
        .counter_zero(counter_zero), .counter_one(counter_one), .halt_cmd(halt_cmd),
        .service_ack(service_ack), .irq(irq), .vector_loc(vector_loc), .cpu_clk_run(cpu_clk_run));

    ssviu_src_model src (.pclk(pclk), .port3_pin(port3_pin), .port_a_data_valid_n(port_a_data_valid_n),
        .port_c_data_valid_n(port_c_data_valid_n), .timer_in_pin(timer_in_pin),
        .counter_zero(counter_zero), .counter_one(counter_one));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic finish_test;
        if (errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // apb transfer; waits for pready with a bound, which counts as a mismatch
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
        output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20)
            errors++;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic e;
        apb(1'b1, a, {24'h000000, d}, rd, e);
        check("pslverr", 32'h0, 32'(e));
    endtask

    task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] rd;
        logic e;
        apb(1'b0, a, 32'h00000000, rd, e);
        check(n, exp, rd);
        check("pslverr", 32'(experr), 32'(e));
    endtask

    // highest ranked enabled request, 7 for none; group digits A=0 B=1 C=2
    function automatic int exp_id(input logic [5:0] p, input logic [7:0] mk, input logic [7:0] rk);
        int tab [8] = '{12, 201, 12, 21, 120, 210, 102, 12};
        int d [3] = '{100, 10, 1};
        int s [3] = '{8, 2, 5};
        int h [3];
        int g;
        logic [5:0] e;
        e = mk[7] ? (p & mk[5:0]) : 6'h00;
        h[0] = rk[5] ? 3 : 5;
        h[1] = rk[4] ? 0 : 2;
        h[2] = rk[3] ? 4 : 1;
        for (int k = 0; k < 3; k++)
        begin
            g = tab[rk[2:0]] / d[k] % 10;
            if (e[h[g]])
                return h[g];
            if (e[s[g] - h[g]])
                return s[g] - h[g];
        end
        return 7;
    endfunction

    task automatic post(input logic [5:0] w);
        src.fire(w);
        #1;
        pend = pend | w;
    endtask

    // acknowledge in expected order until nothing enabled is left
    task automatic serve(input logic [7:0] mk, input logic [7:0] rk);
        int id;
        for (int n = 0; n < 8; n++)
        begin
            id = exp_id(pend, mk, rk);
            check("irq", 32'(id != 7), 32'(irq));
            if (id == 7)
                return;
            check("vector_loc", 32'(2 * id), 32'(vector_loc));
            @(posedge pclk);
            service_ack <= 1'b1;
            @(posedge pclk);
            service_ack <= 1'b0;
            #1;
            pend[id] = 1'b0;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #100000;
        errors++;
        finish_test;
    end

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        check("cpu_clk_run", 32'h1, 32'(cpu_clk_run));
        check("irq", 32'h0, 32'(irq));
        rd_chk("mask", SSVIU_ADDR_MASK, 32'h0, 1'b0);
        rd_chk("status", SSVIU_ADDR_STATUS, 32'h0, 1'b0);
        rd_chk("rank", SSVIU_ADDR_RANK, 32'h0, 1'b0);
        rd_chk("unmapped", 12'h3F4, 32'h0, 1'b1);
        wr(SSVIU_ADDR_MASK, 8'hBF);
        for (int i = 0; i < 6; i++)
        begin
            post(6'(1 << i));
            serve(8'hBF, 8'h00);
        end
        for (int i = 0; i < 3; i++)
        begin
            wr(SSVIU_ADDR_CTRL, (i == 0) ? 8'h01 : 8'(2 * i));
            src.strobe(i);
            #1;
            pend[(i == 0) ? 0 : 2] = 1'b1;
            serve(8'hBF, 8'h00);
        end
        wr(SSVIU_ADDR_CTRL, 8'h00);
        // global enable off: requests still latch but stay silent
        wr(SSVIU_ADDR_MASK, 8'h3F);
        post(6'h3F);
        check("irq", 32'h0, 32'(irq));
        rd_chk("status", SSVIU_ADDR_STATUS, 32'h3F, 1'b0);
        rd_chk("status", SSVIU_ADDR_STATUS, 32'h0, 1'b0);
        pend = 6'h00;
        // corner cases: group C alone swapped, C over B, group A swapped
        wr(SSVIU_ADDR_MASK, 8'hBF);
        wr(SSVIU_ADDR_RANK, 8'h09);
        post(6'h12);
        serve(8'hBF, 8'h09);
        post(6'h03);
        serve(8'hBF, 8'h09);
        wr(SSVIU_ADDR_RANK, 8'h21);
        post(6'h28);
        serve(8'hBF, 8'h21);
        for (int i = 0; i < 24; i++)
        begin
            // only the six legal group orders; reserved codes are left out
            r = {2'h0, 3'($random(seed)), 3'(i % 6 + 1)};
            m = {2'h2, 6'($random(seed))};
            wr(SSVIU_ADDR_RANK, r);
            wr(SSVIU_ADDR_MASK, m);
            rd_chk("mask", SSVIU_ADDR_MASK, 32'(m), 1'b0);
            post(6'($random(seed)));
            serve(m, r);
            // masked leftovers stay pending until the read clears them
            rd_chk("status", SSVIU_ADDR_STATUS, 32'(pend), 1'b0);
            pend = 6'h00;
        end
        wr(SSVIU_ADDR_MASK, 8'hBF);
        @(posedge pclk);
        halt_cmd <= 1'b1;
        @(posedge pclk);
        halt_cmd <= 1'b0;
        #1;
        check("cpu_clk_run", 32'h0, 32'(cpu_clk_run));
        rd_chk("ctrl", SSVIU_ADDR_CTRL, 32'h10, 1'b0);
        src.fire(6'h08);
        #1;
        check("irq", 32'h0, 32'(irq));
        post(6'h02);
        check("cpu_clk_run", 32'h0, 32'(cpu_clk_run));
        @(posedge pclk);
        #1;
        check("cpu_clk_run", 32'h1, 32'(cpu_clk_run));
        serve(8'hBF, 8'h00);
        // the ext_req_d edge seen in halt must not have latched
        rd_chk("status", SSVIU_ADDR_STATUS, 32'h0, 1'b0);
        finish_test;
    end
endmodule
